// *** core/dhs_pkg.sv ***
`default_nettype none
package dhs_pkg;
    // Widths and sizes
    localparam int BYTE_W     = 8;
    localparam int REG_W      = 16;
    localparam int REG_N      = 16;
    localparam int IDX_W      = 4;
    localparam int FIFO_DEPTH = 2;
    // Command opcodes
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ  = 8'h03;
    // Eight-byte test headers, first byte in the top bits
    localparam logic [63:0] SINE_ON_SEQ  = 64'h53ef6e3000000000;
    localparam logic [63:0] SINE_OFF_SEQ = 64'h4578697400000000;
    // Reset values
    localparam logic [15:0] REG_RST = 16'h0000;
    // Serial clock timing of the host end
    localparam int SYS_CLK_MHZ   = 20;
    localparam int SCK_HALF_NS   = 200;
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] PH_RISE = 4'(SCK_HALF_CYC - 1);
    localparam logic [3:0] PH_FALL = 4'(2 * SCK_HALF_CYC - 1);
    // Last bit index of a command and of a stream byte
    localparam logic [5:0] CMD_LAST = 6'd31;
    localparam logic [5:0] STR_LAST = 6'd7;
endpackage
`default_nettype wire

// *** core/dhs_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface dhs_if;
    logic sck;
    logic mosi;
    logic miso;
    logic bus_select_line;
    logic byte_sync;
    logic data_request_flag;
    logic stream_clock;
    logic command_select_n;
    // Board gating: select high passes the clock to the stream port
    assign stream_clock     = sck & bus_select_line;
    assign command_select_n = bus_select_line;
    modport host (
        output sck,
        output mosi,
        output bus_select_line,
        output byte_sync,
        input  miso,
        input  data_request_flag
    );
    modport dev (
        input  sck,
        input  mosi,
        input  stream_clock,
        input  command_select_n,
        input  byte_sync,
        output miso,
        output data_request_flag
    );
endinterface
`default_nettype wire

// *** core/dhs_fifo2.sv ***
`timescale 1ns/100ps
`default_nettype none
module dhs_fifo2 (
    // Clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst,
    // Fill side
    input  wire logic                      i_in_valid,
    input  wire logic [dhs_pkg::BYTE_W-1:0] i_in_data,
    output logic                           o_in_ready,
    // Drain side
    output logic                           o_out_valid,
    output logic [dhs_pkg::BYTE_W-1:0]     o_out_data,
    input  wire logic                      i_out_ready
);
    import dhs_pkg::*;
    logic [BYTE_W-1:0] mem_r [FIFO_DEPTH];
    logic [BYTE_W-1:0] mem_nxt [FIFO_DEPTH];
    logic              wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0]        cnt_r, cnt_nxt;
    logic              push, pop;

    assign o_in_ready  = (cnt_r != 2'(FIFO_DEPTH));
    assign o_out_valid = (cnt_r != 2'd0);
    assign o_out_data  = mem_r[rp_r];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always_comb begin
        wp_nxt  = wp_r ^ push;
        rp_nxt  = rp_r ^ pop;
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem_nxt[i] = (push && wp_r == 1'(i)) ? i_in_data : mem_r[i];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'd0;
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule // dhs_fifo2
`default_nettype wire

// *** core/dhs_device.sv ***
// How it works
// - Host frames each command with select low.
// - Write is opcode 2, address, high, low.
// - Read starts with opcode 3 and address.
// - Device returns high then low byte.
// - Host joins returned bytes, high first.
// - Host sends chunks only while request set.
// - Host raises select before stream bytes.
// - Sync high before byte, low mid-byte.
// - Stream bit sampled on each clock rise.
// - Over-long sync pulses do not break framing.
// - Stream bytes may follow back to back.
// - Exit header stops the sine test.
// - Enter header starts the sine test.
// - Host keeps serial clock low when idle.
`timescale 1ns/100ps
`default_nettype none
module dhs_device (
    // Clock and reset
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst,
    // Link
    dhs_if.dev                              lnk,
    // Register write report
    output logic                            o_wr_stb,
    output logic [dhs_pkg::IDX_W-1:0]       o_wr_idx,
    output logic [dhs_pkg::REG_W-1:0]       o_wr_data,
    // Stream bytes out
    output logic                            o_str_valid,
    output logic [dhs_pkg::BYTE_W-1:0]      o_str_data,
    input  wire logic                       i_str_ready,
    // Test mode
    output logic                            o_sine_on
);
    import dhs_pkg::*;

    typedef enum logic [2:0] {C_OP, C_ADDR, C_HI, C_LO, C_SKIP} dhs_cmd_e;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: sck, select, data, stream clock, sync
    logic [4:0] s1_r, s1_nxt, s2_r, s2_nxt, pv_r, pv_nxt;
    logic       sck_s, csn_s, din_s, sclk_s, bsy_s;
    logic       sck_rise, sck_fall, sclk_rise;

    always_comb begin
        s1_nxt = {lnk.byte_sync, lnk.stream_clock, lnk.mosi,
                  lnk.command_select_n, lnk.sck};
        s2_nxt = s1_r;
        pv_nxt = s2_r;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 5'h02;
            s2_r <= 5'h02;
            pv_r <= 5'h02;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            pv_r <= pv_nxt;
        end
    end

    assign sck_s     = s2_r[0];
    assign csn_s     = s2_r[1];
    assign din_s     = s2_r[2];
    assign sclk_s    = s2_r[3];
    assign bsy_s     = s2_r[4];
    assign sck_rise  = sck_s & ~pv_r[0];
    assign sck_fall  = ~sck_s & pv_r[0];
    assign sclk_rise = sclk_s & ~pv_r[3];

    ////////////////////////////////////////////////////////////////////
    // Command port and register file
    dhs_cmd_e          cst_r, cst_nxt;
    logic [2:0]        cbit_r, cbit_nxt;
    logic [7:0]        crx_r, crx_nxt, rx_byte;
    logic              crd_r, crd_nxt;
    logic [IDX_W-1:0]  cidx_r, cidx_nxt;
    logic [7:0]        chi_r, chi_nxt;
    logic [REG_W-1:0]  ctx_r, ctx_nxt;
    logic              miso_r, miso_nxt;
    logic              wr_r, wr_nxt;
    logic [REG_W-1:0]  wdat_r, wdat_nxt;
    logic [REG_W-1:0]  regs_r [REG_N];
    logic [REG_W-1:0]  regs_nxt [REG_N];

    always_comb begin
        cst_nxt  = cst_r;
        cbit_nxt = cbit_r;
        crx_nxt  = crx_r;
        crd_nxt  = crd_r;
        cidx_nxt = cidx_r;
        chi_nxt  = chi_r;
        ctx_nxt  = ctx_r;
        miso_nxt = miso_r;
        wr_nxt   = 1'b0;
        wdat_nxt = wdat_r;
        regs_nxt = regs_r;
        rx_byte  = {crx_r[6:0], din_s};
        if (csn_s) begin
            // Deselect drops any partial transaction
            cst_nxt  = C_OP;
            cbit_nxt = 3'd0;
            ctx_nxt  = '0;
            miso_nxt = 1'b0;
        end else begin
            // Shift out on falling edge so data is settled at the rise
            if (sck_fall) begin
                miso_nxt = ctx_r[REG_W-1];
            end
            if (sck_rise) begin
                crx_nxt  = rx_byte;
                cbit_nxt = cbit_r + 3'd1;
                ctx_nxt  = {ctx_r[REG_W-2:0], 1'b0};
                if (cbit_r == 3'd7) begin
                    case (cst_r)
                        C_OP: begin
                            crd_nxt = (rx_byte == OP_READ);
                            if (rx_byte == OP_WRITE || rx_byte == OP_READ) begin
                                cst_nxt = C_ADDR;
                            end else begin
                                cst_nxt = C_SKIP;
                            end
                        end
                        C_ADDR: begin
                            // Upper address bits are not decoded
                            cidx_nxt = rx_byte[IDX_W-1:0];
                            ctx_nxt  = regs_r[rx_byte[IDX_W-1:0]];
                            cst_nxt  = C_HI;
                        end
                        C_HI: begin
                            chi_nxt = rx_byte;
                            cst_nxt = C_LO;
                        end
                        C_LO: begin
                            if (!crd_r) begin
                                regs_nxt[cidx_r] = {chi_r, rx_byte};
                                wr_nxt   = 1'b1;
                                wdat_nxt = {chi_r, rx_byte};
                            end
                            cst_nxt = C_SKIP;
                        end
                        default: cst_nxt = C_SKIP;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cst_r  <= C_OP;
            cbit_r <= 3'd0;
            crx_r  <= 8'h00;
            crd_r  <= 1'b0;
            cidx_r <= '0;
            chi_r  <= 8'h00;
            ctx_r  <= '0;
            miso_r <= 1'b0;
            wr_r   <= 1'b0;
            wdat_r <= REG_RST;
            for (int i = 0; i < REG_N; i++) begin
                regs_r[i] <= REG_RST;
            end
        end else begin
            cst_r  <= cst_nxt;
            cbit_r <= cbit_nxt;
            crx_r  <= crx_nxt;
            crd_r  <= crd_nxt;
            cidx_r <= cidx_nxt;
            chi_r  <= chi_nxt;
            ctx_r  <= ctx_nxt;
            miso_r <= miso_nxt;
            wr_r   <= wr_nxt;
            wdat_r <= wdat_nxt;
            regs_r <= regs_nxt;
        end
    end

    assign lnk.miso  = miso_r;
    assign o_wr_stb  = wr_r;
    assign o_wr_idx  = cidx_r;
    assign o_wr_data = wdat_r;

    ////////////////////////////////////////////////////////////////////
    // Stream port, test header detector
    logic [2:0]        sbit_r, sbit_nxt;
    logic [7:0]        ssh_r, ssh_nxt;
    logic              bprev_r, bprev_nxt;
    logic [63:0]       hist_r, hist_nxt;
    logic              sine_r, sine_nxt;
    logic              push_r, push_nxt;
    logic [7:0]        pdat_r, pdat_nxt;
    logic              data_request_flag_r, data_request_flag_nxt;
    logic              fifo_rdy, start;

    always_comb begin
        sbit_nxt  = sbit_r;
        ssh_nxt   = ssh_r;
        bprev_nxt = bprev_r;
        hist_nxt  = hist_r;
        sine_nxt  = sine_r;
        push_nxt  = 1'b0;
        pdat_nxt  = pdat_r;
        data_request_flag_nxt  = fifo_rdy;
        // Only a fresh sync edge realigns, so a long pulse is harmless
        start     = bsy_s & ~bprev_r;
        if (sclk_rise) begin
            bprev_nxt = bsy_s;
            ssh_nxt   = {ssh_r[6:0], din_s};
            sbit_nxt  = start ? 3'd1 : sbit_r + 3'd1;
            if (start) begin
                ssh_nxt = {7'h00, din_s};
            end else if (sbit_r == 3'd7) begin
                // Counter wraps, next byte may start at once
                push_nxt = 1'b1;
                pdat_nxt = ssh_nxt;
                hist_nxt = {hist_r[55:0], ssh_nxt};
                if (hist_nxt == SINE_ON_SEQ) begin
                    sine_nxt = 1'b1;
                end else if (hist_nxt == SINE_OFF_SEQ) begin
                    sine_nxt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sbit_r  <= 3'd0;
            ssh_r   <= 8'h00;
            bprev_r <= 1'b0;
            hist_r  <= 64'h0;
            sine_r  <= 1'b0;
            push_r  <= 1'b0;
            pdat_r  <= 8'h00;
            data_request_flag_r  <= 1'b0;
        end else begin
            sbit_r  <= sbit_nxt;
            ssh_r   <= ssh_nxt;
            bprev_r <= bprev_nxt;
            hist_r  <= hist_nxt;
            sine_r  <= sine_nxt;
            push_r  <= push_nxt;
            pdat_r  <= pdat_nxt;
            data_request_flag_r  <= data_request_flag_nxt;
        end
    end

    // Request drops when buffer is full; a byte sent anyway is lost
    dhs_fifo2 u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_in_valid  (push_r),
        .i_in_data   (pdat_r),
        .o_in_ready  (fifo_rdy),
        .o_out_valid (o_str_valid),
        .o_out_data  (o_str_data),
        .i_out_ready (i_str_ready)
    );

    assign lnk.data_request_flag = data_request_flag_r;
    assign o_sine_on             = sine_r;
endmodule // dhs_device
`default_nettype wire

// *** core/dhs_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module dhs_host (
    // Clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst,
    // Link
    dhs_if.host                            lnk,
    // Command request
    input  wire logic                      i_cmd_valid,
    input  wire logic                      i_cmd_write,
    input  wire logic [7:0]                i_cmd_addr,
    input  wire logic [dhs_pkg::REG_W-1:0] i_cmd_wdata,
    output logic                           o_cmd_ready,
    // Read answer
    output logic                           o_rd_valid,
    output logic [dhs_pkg::REG_W-1:0]      o_rd_data,
    // Stream bytes in
    input  wire logic                      i_str_valid,
    input  wire logic [dhs_pkg::BYTE_W-1:0] i_str_data,
    output logic                           o_str_ready
);
    import dhs_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_LEAD, H_SHIFT, H_TAIL} dhs_hst_e;

    ////////////////////////////////////////////////////////////////////
    // Synchronisers for returned data and request flag
    logic [1:0] y1_r, y2_r;
    logic       miso_s, data_request_flag_s;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            y1_r <= 2'b00;
            y2_r <= 2'b00;
        end else begin
            y1_r <= {lnk.data_request_flag, lnk.miso};
            y2_r <= y1_r;
        end
    end

    assign miso_s = y2_r[0];
    assign data_request_flag_s = y2_r[1];

    ////////////////////////////////////////////////////////////////////
    // Serial engine
    dhs_hst_e    st_r, st_nxt;
    logic [3:0]  ph_r, ph_nxt;
    logic [5:0]  bit_r, bit_nxt;
    logic        sck_r, sck_nxt, mosi_r, mosi_nxt;
    logic        sel_r, sel_nxt, bsy_r, bsy_nxt;
    logic        str_r, str_nxt, rd_r, rd_nxt;
    logic [31:0] tx_r, tx_nxt, rx_r, rx_nxt;
    logic        rdv_r, rdv_nxt;
    logic [15:0] rdd_r, rdd_nxt;

    assign o_cmd_ready = (st_r == H_IDLE);
    assign o_str_ready = (st_r == H_IDLE) & ~i_cmd_valid & data_request_flag_s;

    always_comb begin
        st_nxt   = st_r;
        ph_nxt   = ph_r + 4'd1;
        bit_nxt  = bit_r;
        sck_nxt  = sck_r;
        mosi_nxt = mosi_r;
        sel_nxt  = sel_r;
        bsy_nxt  = bsy_r;
        str_nxt  = str_r;
        rd_nxt   = rd_r;
        tx_nxt   = tx_r;
        rx_nxt   = rx_r;
        rdv_nxt  = 1'b0;
        rdd_nxt  = rdd_r;
        case (st_r)
            H_IDLE: begin
                ph_nxt  = 4'd0;
                bit_nxt = 6'd0;
                sck_nxt = 1'b0;
                if (i_cmd_valid) begin
                    tx_nxt  = {i_cmd_write ? OP_WRITE : OP_READ, i_cmd_addr,
                               i_cmd_write ? i_cmd_wdata : 16'h0000};
                    rd_nxt  = ~i_cmd_write;
                    str_nxt = 1'b0;
                    sel_nxt = 1'b0;
                    st_nxt  = H_LEAD;
                end else if (i_str_valid && data_request_flag_s) begin
                    tx_nxt  = {i_str_data, 24'h000000};
                    str_nxt = 1'b1;
                    sel_nxt = 1'b1;
                    bsy_nxt = 1'b1;
                    st_nxt  = H_LEAD;
                end
            end
            H_LEAD: begin
                if (ph_r == PH_RISE) begin
                    ph_nxt   = 4'd0;
                    mosi_nxt = tx_r[31];
                    st_nxt   = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (ph_r == PH_RISE) begin
                    sck_nxt = 1'b1;
                end
                // Sample late in the high phase to cover sync delays
                if (ph_r == PH_FALL) begin
                    ph_nxt   = 4'd0;
                    sck_nxt  = 1'b0;
                    bsy_nxt  = 1'b0;
                    rx_nxt   = {rx_r[30:0], miso_s};
                    tx_nxt   = {tx_r[30:0], 1'b0};
                    mosi_nxt = tx_r[30];
                    bit_nxt  = bit_r + 6'd1;
                    if (bit_r == (str_r ? STR_LAST : CMD_LAST)) begin
                        st_nxt = H_TAIL;
                    end
                end
            end
            H_TAIL: begin
                if (ph_r == PH_RISE) begin
                    st_nxt = H_IDLE;
                    if (!str_r) begin
                        sel_nxt = 1'b1;
                        rdv_nxt = rd_r;
                        if (rd_r) begin
                            rdd_nxt = rx_r[15:0];
                        end
                    end
                end
            end
            default: st_nxt = H_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r   <= H_IDLE;
            ph_r   <= 4'd0;
            bit_r  <= 6'd0;
            sck_r  <= 1'b0;
            mosi_r <= 1'b0;
            sel_r  <= 1'b1;
            bsy_r  <= 1'b0;
            str_r  <= 1'b0;
            rd_r   <= 1'b0;
            tx_r   <= 32'h0;
            rx_r   <= 32'h0;
            rdv_r  <= 1'b0;
            rdd_r  <= 16'h0000;
        end else begin
            st_r   <= st_nxt;
            ph_r   <= ph_nxt;
            bit_r  <= bit_nxt;
            sck_r  <= sck_nxt;
            mosi_r <= mosi_nxt;
            sel_r  <= sel_nxt;
            bsy_r  <= bsy_nxt;
            str_r  <= str_nxt;
            rd_r   <= rd_nxt;
            tx_r   <= tx_nxt;
            rx_r   <= rx_nxt;
            rdv_r  <= rdv_nxt;
            rdd_r  <= rdd_nxt;
        end
    end

    assign lnk.sck             = sck_r;
    assign lnk.mosi            = mosi_r;
    assign lnk.bus_select_line = sel_r;
    assign lnk.byte_sync       = bsy_r;
    assign o_rd_valid          = rdv_r;
    assign o_rd_data           = rdd_r;
endmodule // dhs_host
`default_nettype wire

// *** verification/dhs_link_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module dhs_link_sva (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // Link
    input  wire logic sck,
    input  wire logic stream_clock,
    input  wire logic bus_select_line,
    input  wire logic byte_sync,
    input  wire logic data_request_flag
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [5:0] cmd_rise_r, cmd_rise_nxt;
    logic [3:0] str_rise_r, str_rise_nxt;
    logic       sck_d_r, stc_d_r, bs_d_r;
    ////////////////////////////////////////////////////////////////////
    // Rises counted per frame; sck is a host flop, so no sync needed
    always_comb begin
        cmd_rise_nxt = bus_select_line ? 6'h00
                     : cmd_rise_r + 6'(sck & ~sck_d_r);
        str_rise_nxt = (byte_sync & ~bs_d_r) ? 4'h0
                     : str_rise_r + 4'(stream_clock & ~stc_d_r);
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cmd_rise_r <= 6'h00;
            str_rise_r <= 4'h0;
            sck_d_r    <= 1'b0;
            stc_d_r    <= 1'b0;
            bs_d_r     <= 1'b0;
        end else begin
            cmd_rise_r <= cmd_rise_nxt;
            str_rise_r <= str_rise_nxt;
            sck_d_r    <= sck;
            stc_d_r    <= stream_clock;
            bs_d_r     <= byte_sync;
        end
    end
    ////////////////////////////////////////////////////////////////////
    AST_CMD_BITS: assert property ($rose(bus_select_line) |->
        cmd_rise_r == 6'h20) else $error("command frame not 32 bits");
    AST_STR_BITS: assert property ($rose(byte_sync) |->
        (str_rise_r == 4'h8 || str_rise_r == 4'h0))
        else $error("stream byte not 8 bits");
    AST_RISE_CAP: assert property (str_rise_r <= 4'h8
        && cmd_rise_r <= 6'h20) else $error("clock runs outside frame");
    AST_SEL_LEAD: assert property ($fell(bus_select_line) |->
        !sck [*4]) else $error("clock too soon after select");
    AST_SYNC_HOLD: assert property ($rose(byte_sync) |->
        (bus_select_line && byte_sync) [*8] ##[1:8] !byte_sync)
        else $error("byte sync framing wrong");
    AST_SYNC_FIRST: assert property ($rose(byte_sync) |->
        !sck [*6]) else $error("byte started before sync");
    AST_SYNC_FALL: assert property ($fell(byte_sync) |->
        str_rise_r inside {[4'h1:4'h7]}) else $error("sync fell late");
    AST_REQ_SEEN: assert property ($rose(byte_sync) |->
        (data_request_flag || $past(data_request_flag)
        || $past(data_request_flag, 2) || $past(data_request_flag, 3)
        || $past(data_request_flag, 4))) else $error("byte without request");
    AST_CLK_GATE: assert property (!bus_select_line |->
        (!stream_clock && !byte_sync))
        else $error("stream lines active during command");
endmodule // dhs_link_sva
`default_nettype wire

// *** verification/decoder_host_serial_ports_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module decoder_host_serial_ports_bench;
    import dhs_pkg::*;
    logic        i_sys_clk = 1'b0, i_rst = 1'b1;
    logic        cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, rd_valid;
    logic [7:0]  cmd_addr = 8'h00, str_data = 8'h00, dv_data;
    logic [15:0] cmd_wdata = 16'h0000, rd_data, wr_data, rd_seen, miso_sh;
    logic        str_valid = 1'b0, str_ready, wr_stb, dv_valid, sine_on;
    logic        drain_ready = 1'b1;
    logic [3:0]  wr_idx;
    logic [19:0] wr_seen;
    logic [31:0] wire_sh;
    logic [7:0]  rx_q[$];
    int          failures = 0, num_checks = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    ////////////////////////////////////////////////////////////////////
    dhs_if dhs_if_inst ();
    dhs_host dhs_host_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .lnk(dhs_if_inst.host), .i_cmd_valid(cmd_valid),
        .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
        .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .i_str_valid(str_valid), .i_str_data(str_data),
        .o_str_ready(str_ready));
    dhs_device dhs_device_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .lnk(dhs_if_inst.dev), .o_wr_stb(wr_stb), .o_wr_idx(wr_idx),
        .o_wr_data(wr_data), .o_str_valid(dv_valid), .o_str_data(dv_data),
        .i_str_ready(drain_ready), .o_sine_on(sine_on));
    dhs_link_sva dhs_link_sva_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .sck(dhs_if_inst.sck), .stream_clock(dhs_if_inst.stream_clock),
        .bus_select_line(dhs_if_inst.bus_select_line),
        .byte_sync(dhs_if_inst.byte_sync),
        .data_request_flag(dhs_if_inst.data_request_flag));
    ////////////////////////////////////////////////////////////////////
    // Wire watch: both lines settle well before the rise
    always @(posedge dhs_if_inst.sck) begin
        wire_sh <= {wire_sh[30:0], dhs_if_inst.mosi};
        miso_sh <= {miso_sh[14:0], dhs_if_inst.miso};
    end
    always @(posedge i_sys_clk) begin
        if (wr_stb === 1'b1) wr_seen <= {wr_idx, wr_data};
        if (rd_valid === 1'b1) rd_seen <= rd_data;
        if (dv_valid === 1'b1 && drain_ready) rx_q.push_back(dv_data);
    end
    ////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic give_up(input logic ok);
        chk(32'h1, {31'h0, ok});
        if (ok !== 1'b1) test_done();
    endtask
    task automatic cmd(input logic wr, input logic [7:0] a,
                       input logic [15:0] d);
        int n;
        @(negedge i_sys_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr  = a;
        cmd_wdata = d;
        for (n = 0; n < 400 && cmd_ready !== 1'b1; n++) @(negedge i_sys_clk);
        give_up(cmd_ready);
        @(negedge i_sys_clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 400 && cmd_ready !== 1'b1; n++) @(negedge i_sys_clk);
        give_up(cmd_ready);
        repeat (2) @(negedge i_sys_clk);
    endtask
    // Valid stays up between bytes so they can go back to back
    task automatic put(input logic [7:0] b);
        int n;
        @(negedge i_sys_clk);
        str_valid = 1'b1;
        str_data  = b;
        for (n = 0; n < 400 && str_ready !== 1'b1; n++) @(negedge i_sys_clk);
        give_up(str_ready);
    endtask
    task automatic put_seq(input logic [63:0] s);
        for (int i = 0; i < 8; i++) put(s[63 - 8 * i -: 8]);
        @(negedge i_sys_clk);
        str_valid = 1'b0;
        repeat (300) @(negedge i_sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge i_sys_clk);
        i_rst = 1'b0;
        cmd(1'b1, 8'h0b, 16'h0407);
        chk({OP_WRITE, 8'h0b, 16'h0407}, wire_sh);
        chk({12'h000, 4'hb, 16'h0407}, {12'h000, wr_seen});
        cmd(1'b1, 8'h1f, 16'ha2f5);
        chk({12'h000, 4'hf, 16'ha2f5}, {12'h000, wr_seen});
        cmd(1'b0, 8'h0b, 16'h0000);
        chk({16'h0, 16'h0407}, {16'h0, rd_seen});
        cmd(1'b0, 8'h0f, 16'h0000);
        chk({OP_READ, 8'h0f}, {16'h0, wire_sh[31:16]});
        chk({16'h0, 16'ha2f5}, {16'h0, miso_sh});
        chk({16'h0, 16'ha2f5}, {16'h0, rd_seen});
        $display("test registers done");
        drain_ready = 1'b0;
        put(8'h45);
        put(8'h78);
        @(negedge i_sys_clk);
        str_data = 8'h69;
        repeat (200) @(negedge i_sys_clk);
        chk(32'h0, {31'h0, str_ready});
        chk(32'h0, {31'h0, dhs_if_inst.data_request_flag});
        chk(32'h0, rx_q.size());
        drain_ready = 1'b1;
        put(8'h69);
        @(negedge i_sys_clk);
        str_valid = 1'b0;
        repeat (200) @(negedge i_sys_clk);
        chk(32'h3, rx_q.size());
        chk(32'h00457869, {8'h0, rx_q[0], rx_q[1], rx_q[2]});
        chk(32'h69, {24'h0, wire_sh[7:0]});
        rx_q.delete();
        $display("test buffer done");
        put_seq(SINE_ON_SEQ);
        chk(32'h1, {31'h0, sine_on});
        chk(32'h8, rx_q.size());
        put_seq(SINE_OFF_SEQ);
        chk(32'h0, {31'h0, sine_on});
        $display("test sine done");
        test_done();
    end
endmodule // decoder_host_serial_ports_bench
`default_nettype wire
